// [hdl/shba_consts.svh]
// Register offsets, field positions and cycle counts of the hash block accelerator.
// Assumes a byte-addressed 32-bit classic Wishbone slave port with 8 address bits.
//
// What this block does
// [RQ1] Hash with SHA-1, SHA-256, SHA-384, SHA-512
// [RQ2] One block per command, no queue
// [RQ3] Software splits message, loads whole block first
// [RQ4] Narrow algorithms use words 0 to 15
// [RQ5] Wide algorithms use words 0 to 31
// [RQ6] Software pads message, engine never pads
// [RQ7] Word 0 is leftmost block word
// [RQ8] Digest overwrites the message words
// [RQ9] SHA-1 digest in words 0 to 4
// [RQ10] SHA-256 digest in words 0 to 7
// [RQ11] SHA-384 digest in words 0 to 11
// [RQ12] SHA-512 digest in words 0 to 15
// [RQ13] Leftmost digest word lands in word 0
// [RQ14] Per-algorithm command set selects the algorithm
// [RQ15] First-block command restarts from initial hash
// [RQ16] Next-block command updates running hash
// [RQ17] Busy reads 0 when block done
// [RQ18] Finalize command, then busy 0, then read
// [RQ19] Block takes 60 to 100 cycles
// [RQ20] Finalize takes 8 to 20 cycles
// [RQ21] Busy reads 1 while processing
// [RQ22] Commands and word writes ignored while busy
`ifndef SHBA_CONSTS_SVH
`define SHBA_CONSTS_SVH

`define SHBA_CMD_TOP 2'h2
`define SHBA_OP_FIRST 2'h0
`define SHBA_OP_NEXT 2'h1
`define SHBA_OP_FIN 2'h2
`define SHBA_OP_BUSY 2'h3
`define SHBA_ROUNDS_NARROW 7'h40
`define SHBA_ROUNDS_OTHER 7'h50
`define SHBA_S1 7'h14
`define SHBA_S2 7'h28
`define SHBA_S3 7'h3C
`define SHBA_FIN_CYC 7'h0A
`define SHBA_DIG_160 6'h05
`define SHBA_DIG_256 6'h08
`define SHBA_DIG_384 6'h0C
`define SHBA_DIG_512 6'h10

`endif

// [hdl/shba_pkg.sv]
// Types shared by the hash block accelerator and its bench.
// Assumes the Wishbone signals of one classic slave port.
package shba_pkg;
  // Algorithm code; bit 1 marks the 64-bit word algorithms
  typedef enum logic [1:0] {
    SHBA_A160 = 2'b00,
    SHBA_A256 = 2'b01,
    SHBA_A384 = 2'b10,
    SHBA_A512 = 2'b11
  } shba_alg_e;
  // Sequencer states
  typedef enum logic [2:0] {
    SHBA_IDLE = 3'b000,
    SHBA_ROUND = 3'b001,
    SHBA_FOLD = 3'b010,
    SHBA_WAIT = 3'b011,
    SHBA_PUB = 3'b100
  } shba_st_e;
  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } shba_wb_req_s;
  // Wishbone answer to the master
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } shba_wb_rsp_s;
endpackage

// [hdl/shba_top.sv]
// Hash block accelerator: 32 word registers, four command sets and one round engine.
// Assumes a classic Wishbone master on clk_i and software that pads and splits messages.
`include "shba_consts.svh"
`timescale 1ns/1ps
module shba_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire shba_pkg::shba_wb_req_s wb_i,
  output shba_pkg::shba_wb_rsp_s wb_o
);
  import shba_pkg::*;

  // Round constants; the narrow algorithm uses the upper halves of the first 64
  localparam logic [63:0] KT [80] = '{
    64'h428a_2f98_d728_ae22, 64'h7137_4491_23ef_65cd, 64'hb5c0_fbcf_ec4d_3b2f, 64'he9b5_dba5_8189_dbbc,
    64'h3956_c25b_f348_b538, 64'h59f1_11f1_b605_d019, 64'h923f_82a4_af19_4f9b, 64'hab1c_5ed5_da6d_8118,
    64'hd807_aa98_a303_0242, 64'h1283_5b01_4570_6fbe, 64'h2431_85be_4ee4_b28c, 64'h550c_7dc3_d5ff_b4e2,
    64'h72be_5d74_f27b_896f, 64'h80de_b1fe_3b16_96b1, 64'h9bdc_06a7_25c7_1235, 64'hc19b_f174_cf69_2694,
    64'he49b_69c1_9ef1_4ad2, 64'hefbe_4786_384f_25e3, 64'h0fc1_9dc6_8b8c_d5b5, 64'h240c_a1cc_77ac_9c65,
    64'h2de9_2c6f_592b_0275, 64'h4a74_84aa_6ea6_e483, 64'h5cb0_a9dc_bd41_fbd4, 64'h76f9_88da_8311_53b5,
    64'h983e_5152_ee66_dfab, 64'ha831_c66d_2db4_3210, 64'hb003_27c8_98fb_213f, 64'hbf59_7fc7_beef_0ee4,
    64'hc6e0_0bf3_3da8_8fc2, 64'hd5a7_9147_930a_a725, 64'h06ca_6351_e003_826f, 64'h1429_2967_0a0e_6e70,
    64'h27b7_0a85_46d2_2ffc, 64'h2e1b_2138_5c26_c926, 64'h4d2c_6dfc_5ac4_2aed, 64'h5338_0d13_9d95_b3df,
    64'h650a_7354_8baf_63de, 64'h766a_0abb_3c77_b2a8, 64'h81c2_c92e_47ed_aee6, 64'h9272_2c85_1482_353b,
    64'ha2bf_e8a1_4cf1_0364, 64'ha81a_664b_bc42_3001, 64'hc24b_8b70_d0f8_9791, 64'hc76c_51a3_0654_be30,
    64'hd192_e819_d6ef_5218, 64'hd699_0624_5565_a910, 64'hf40e_3585_5771_202a, 64'h106a_a070_32bb_d1b8,
    64'h19a4_c116_b8d2_d0c8, 64'h1e37_6c08_5141_ab53, 64'h2748_774c_df8e_eb99, 64'h34b0_bcb5_e19b_48a8,
    64'h391c_0cb3_c5c9_5a63, 64'h4ed8_aa4a_e341_8acb, 64'h5b9c_ca4f_7763_e373, 64'h682e_6ff3_d6b2_b8a3,
    64'h748f_82ee_5def_b2fc, 64'h78a5_636f_4317_2f60, 64'h84c8_7814_a1f0_ab72, 64'h8cc7_0208_1a64_39ec,
    64'h90be_fffa_2363_1e28, 64'ha450_6ceb_de82_bde9, 64'hbef9_a3f7_b2c6_7915, 64'hc671_78f2_e372_532b,
    64'hca27_3ece_ea26_619c, 64'hd186_b8c7_21c0_c207, 64'heada_7dd6_cde0_eb1e, 64'hf57d_4f7f_ee6e_d178,
    64'h06f0_67aa_7217_6fba, 64'h0a63_7dc5_a2c8_98a6, 64'h113f_9804_bef9_0dae, 64'h1b71_0b35_131c_471b,
    64'h28db_77f5_2304_7d84, 64'h32ca_ab7b_40c7_2493, 64'h3c9e_be0a_15c9_bebc, 64'h431d_67c4_9c10_0d4c,
    64'h4cc5_d4be_cb3e_42b6, 64'h597f_299c_fc65_7e2a, 64'h5fcb_6fab_3ad6_faec, 64'h6c44_198c_4a47_5817};
  // Initial hash values, indexed by algorithm code
  localparam logic [63:0] IV [4][8] = '{
    '{64'h6745_2301, 64'hefcd_ab89, 64'h98ba_dcfe, 64'h1032_5476, 64'hc3d2_e1f0, 64'h0, 64'h0, 64'h0},
    '{64'h6a09_e667, 64'hbb67_ae85, 64'h3c6e_f372, 64'ha54f_f53a,
      64'h510e_527f, 64'h9b05_688c, 64'h1f83_d9ab, 64'h5be0_cd19},
    '{64'hcbbb_9d5d_c105_9ed8, 64'h629a_292a_367c_d507, 64'h9159_015a_3070_dd17, 64'h152f_ecd8_f70e_5939,
      64'h6733_2667_ffc0_0b31, 64'h8eb4_4a87_6858_1511, 64'hdb0c_2e0d_64f9_8fa7, 64'h47b5_481d_befa_4fa4},
    '{64'h6a09_e667_f3bc_c908, 64'hbb67_ae85_84ca_a73b, 64'h3c6e_f372_fe94_f82b, 64'ha54f_f53a_5f1d_36f1,
      64'h510e_527f_ade6_82d1, 64'h9b05_688c_2b3e_6c1f, 64'h1f83_d9ab_fb41_bd6b, 64'h5be0_cd19_137e_2179}};
  // Constants of the 160-bit algorithm, one per stage of twenty rounds
  localparam logic [31:0] K1 [4] = '{32'h5a82_7999, 32'h6ed9_eba1, 32'h8f1b_bcdc, 32'hca62_c1d6};

  // Rotate right helpers
  function automatic logic [31:0] r32(input logic [31:0] x, input int n);
    return (x >> n) | (x << (32 - n));
  endfunction
  function automatic logic [63:0] r64(input logic [63:0] x, input int n);
    return (x >> n) | (x << (64 - n));
  endfunction

  logic [31:0] word_r [32]; // Message block in, digest out
  logic [63:0] hs_r [8]; // Running hash value
  logic [63:0] v_r [8]; // Working variables a..h
  logic [63:0] w_r [16]; // Sliding window of the message schedule
  logic [63:0] vn [8]; // Working variables after this round
  logic [63:0] hsum [8]; // Hash value plus working variables
  logic [31:0] dig [32]; // Digest laid out as words
  shba_st_e st_r; // Sequencer state
  shba_alg_e alg_r; // Algorithm of the last accepted command
  logic [6:0] cnt_r; // Round or wait counter
  logic ack_r; // Bus acknowledge
  logic [31:0] rdat_r; // Bus read data

  // Bus decode
  wire req = wb_i.cyc & wb_i.stb;
  wire wr_go = req & wb_i.we & ack_r; // Write lands at the edge the master sees ack
  wire idle = (st_r == SHBA_IDLE);
  wire is_word = ~wb_i.adr[7];
  wire [4:0] widx = wb_i.adr[6:2];
  wire is_cmd = (wb_i.adr[7:6] == `SHBA_CMD_TOP);
  wire [1:0] c_op = wb_i.adr[3:2];
  wire shba_alg_e c_alg = shba_alg_e'(wb_i.adr[5:4]);
  // Commands only count while idle; a busy engine drops them silently
  wire cmd_go = wr_go & is_cmd & wb_i.sel[0] & wb_i.dat[0] & idle & (c_op != `SHBA_OP_BUSY); // see RQ22
  wire word_wr = wr_go & is_word & idle; // see RQ22
  wire wide = alg_r[1];
  wire c_wide = c_alg[1];
  wire [6:0] last_rnd = (alg_r == SHBA_A256) ? `SHBA_ROUNDS_NARROW - 7'h01 : `SHBA_ROUNDS_OTHER - 7'h01;

  // Busy of one command set reads 1 only for the algorithm in flight
  wire busy_sel = ~idle & (alg_r == c_alg); // see RQ21 see RQ17
  wire [31:0] rd_val = is_word ? word_r[widx] :
                       (is_cmd && c_op == `SHBA_OP_BUSY) ? {31'h0, busy_sel} : 32'h0;

  // Bus answer: one wait state, every address answered, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
    end else begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r) begin
        rdat_r <= rd_val;
      end
    end
  end
  assign wb_o.ack = ack_r;
  assign wb_o.dat = rdat_r;

  // Round logic for all four algorithms
  wire [63:0] wt = w_r[0];
  wire [63:0] kt = KT[cnt_r];
  wire [1:0] k1i = (cnt_r < `SHBA_S1) ? 2'h0 : (cnt_r < `SHBA_S2) ? 2'h1 : (cnt_r < `SHBA_S3) ? 2'h2 : 2'h3;
  wire [31:0] b1 = v_r[1][31:0];
  wire [31:0] c1 = v_r[2][31:0];
  wire [31:0] d1 = v_r[3][31:0];
  wire [31:0] f1 = (k1i == 2'h0) ? ((b1 & c1) | (~b1 & d1)) :
                   (k1i == 2'h2) ? ((b1 & c1) | (b1 & d1) | (c1 & d1)) : (b1 ^ c1 ^ d1);
  wire [31:0] t1 = {v_r[0][26:0], v_r[0][31:27]} + f1 + v_r[4][31:0] + K1[k1i] + wt[31:0]; // see RQ1
  wire [63:0] ch2 = (v_r[4] & v_r[5]) ^ (~v_r[4] & v_r[6]);
  wire [63:0] mj2 = (v_r[0] & v_r[1]) ^ (v_r[0] & v_r[2]) ^ (v_r[1] & v_r[2]);
  wire [31:0] e32 = v_r[4][31:0];
  wire [31:0] a32 = v_r[0][31:0];
  wire [31:0] sa32 = r32(e32, 6) ^ r32(e32, 11) ^ r32(e32, 25);
  wire [31:0] sb32 = r32(a32, 2) ^ r32(a32, 13) ^ r32(a32, 22);
  wire [31:0] ta32 = v_r[7][31:0] + sa32 + ch2[31:0] + kt[63:32] + wt[31:0];
  wire [31:0] tb32 = sb32 + mj2[31:0];
  wire [63:0] sa64 = r64(v_r[4], 14) ^ r64(v_r[4], 18) ^ r64(v_r[4], 41);
  wire [63:0] sb64 = r64(v_r[0], 28) ^ r64(v_r[0], 34) ^ r64(v_r[0], 39);
  wire [63:0] ta64 = v_r[7] + sa64 + ch2 + kt + wt;
  wire [63:0] tb64 = sb64 + mj2;

  // Schedule word sixteen places ahead of the current one
  wire [31:0] x1 = w_r[13][31:0] ^ w_r[8][31:0] ^ w_r[2][31:0] ^ w_r[0][31:0];
  wire [31:0] q1 = w_r[1][31:0];
  wire [31:0] q14 = w_r[14][31:0];
  wire [31:0] ws32 = (r32(q14, 17) ^ r32(q14, 19) ^ (q14 >> 10)) + w_r[9][31:0] +
                     (r32(q1, 7) ^ r32(q1, 18) ^ (q1 >> 3)) + w_r[0][31:0];
  wire [63:0] ws64 = (r64(w_r[14], 19) ^ r64(w_r[14], 61) ^ (w_r[14] >> 6)) + w_r[9] +
                     (r64(w_r[1], 1) ^ r64(w_r[1], 8) ^ (w_r[1] >> 7)) + w_r[0];
  logic [63:0] wn;
  always_comb begin
    unique case (alg_r)
      SHBA_A160: wn = {32'h0, x1[30:0], x1[31]};
      SHBA_A256: wn = {32'h0, ws32};
      SHBA_A384, SHBA_A512: wn = ws64;
    endcase
  end

  // Working variables shift down; a takes the fresh sum, e too for the 256/384/512 algorithms, c takes b rotated for the 160-bit one
  always_comb begin
    vn[0] = v_r[0];
    for (int i = 1; i < 8; i++) begin
      vn[i] = v_r[i - 1];
    end
    unique case (alg_r)
      SHBA_A160: begin
        vn[0] = {32'h0, t1};
        vn[2] = {32'h0, v_r[1][1:0], v_r[1][31:2]};
      end
      SHBA_A256: begin
        vn[0] = {32'h0, ta32 + tb32};
        vn[4] = {32'h0, d1 + ta32};
      end
      SHBA_A384, SHBA_A512: begin
        vn[0] = ta64 + tb64;
        vn[4] = v_r[3] + ta64;
      end
    endcase
  end

  // Fold the block result into the hash; narrow algorithms wrap at 32 bits
  // Digest words: leftmost hash word first, high half before low half
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_fold
      wire [31:0] lo = hs_r[g][31:0] + v_r[g][31:0];
      assign hsum[g] = wide ? hs_r[g] + v_r[g] : {32'h0, lo};
    end
    for (g = 0; g < 32; g++) begin : g_dig
      // Odd registers take the low half; the parity is worked out from the index, not a bit of it
      assign dig[g] = wide ? ((g % 2 == 1) ? hs_r[g / 2][31:0] : hs_r[g / 2][63:32]) : hs_r[g % 8][31:0]; // see RQ13
    end
  endgenerate
  wire [5:0] dig_n = (alg_r == SHBA_A160) ? `SHBA_DIG_160 : // see RQ9
                     (alg_r == SHBA_A256) ? `SHBA_DIG_256 : // see RQ10
                     (alg_r == SHBA_A384) ? `SHBA_DIG_384 : `SHBA_DIG_512; // see RQ11 see RQ12

  // Sequencer: idle, rounds, fold, publish; finalize waits then publishes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= SHBA_IDLE;
      alg_r <= SHBA_A160;
      cnt_r <= 7'h0;
    end else begin
      unique case (st_r)
        SHBA_IDLE: begin
          cnt_r <= 7'h0;
          if (cmd_go) begin
            alg_r <= c_alg; // see RQ14
            st_r <= (c_op == `SHBA_OP_FIN) ? SHBA_WAIT : SHBA_ROUND; // see RQ18
          end
        end
        SHBA_ROUND: begin
          cnt_r <= cnt_r + 7'h01;
          if (cnt_r == last_rnd) begin
            st_r <= SHBA_FOLD; // see RQ19
          end
        end
        SHBA_FOLD: st_r <= SHBA_PUB;
        SHBA_WAIT: begin
          cnt_r <= cnt_r + 7'h01;
          if (cnt_r == `SHBA_FIN_CYC - 7'h01) begin
            st_r <= SHBA_PUB; // see RQ20
          end
        end
        SHBA_PUB: st_r <= SHBA_IDLE;
        default: st_r <= SHBA_IDLE;
      endcase
    end
  end

  // Datapath: a command takes the single stored block, nothing is queued behind it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        hs_r[i] <= 64'h0;
        v_r[i] <= 64'h0;
      end
      for (int i = 0; i < 16; i++) begin
        w_r[i] <= 64'h0;
      end
    end else if (cmd_go && c_op != `SHBA_OP_FIN) begin
      for (int i = 0; i < 16; i++) begin
        // Word 0 is leftmost; wide words pair two registers, high first
        w_r[i] <= c_wide ? {word_r[2 * i], word_r[2 * i + 1]} : {32'h0, word_r[i]}; // see RQ2 see RQ4 see RQ5 see RQ7
      end
      for (int i = 0; i < 8; i++) begin
        if (c_op == `SHBA_OP_FIRST) begin
          hs_r[i] <= IV[c_alg][i]; // see RQ15
          v_r[i] <= IV[c_alg][i];
        end else begin
          v_r[i] <= hs_r[i]; // see RQ16
        end
      end
    end else if (st_r == SHBA_ROUND) begin
      v_r <= vn;
      for (int i = 0; i < 15; i++) begin
        w_r[i] <= w_r[i + 1];
      end
      w_r[15] <= wn;
    end else if (st_r == SHBA_FOLD) begin
      hs_r <= hsum;
    end
  end

  // Word registers: bus writes by byte lane while idle, digest on publish
  generate
    for (g = 0; g < 32; g++) begin : g_word
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          word_r[g] <= 32'h0;
        end else if (st_r == SHBA_PUB && g < dig_n) begin
          word_r[g] <= dig[g]; // see RQ8
        end else if (word_wr && widx == g) begin
          for (int b = 0; b < 4; b++) begin
            if (wb_i.sel[b]) begin
              word_r[g][8 * b +: 8] <= wb_i.dat[8 * b +: 8];
            end
          end
        end
      end
    end
  endgenerate

  // Checking helpers: cycles since the last command and its kind
  logic [7:0] tm_r;
  logic fin_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tm_r <= 8'h0;
      fin_r <= 1'b0;
    end else if (cmd_go) begin
      tm_r <= 8'h0;
      fin_r <= (c_op == `SHBA_OP_FIN);
    end else if (!idle) begin
      tm_r <= tm_r + 8'h01;
    end
  end

  a_block_time: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ19
    (st_r == SHBA_PUB && !fin_r) |-> (tm_r >= 8'd59 && tm_r <= 8'd98))
    else $error("block time out of range");
  a_fin_time: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ20
    (st_r == SHBA_PUB && fin_r) |-> (tm_r >= 8'd7 && tm_r <= 8'd19))
    else $error("finalize time out of range");
  a_busy_drops_cmd: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ22
    (!idle && wr_go && is_cmd && st_r != SHBA_PUB) |=> ($stable(alg_r) && st_r != SHBA_IDLE))
    else $error("command taken while busy");
  a_cmd_sets_busy: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ21
    cmd_go |=> (!idle && alg_r == $past(c_alg)) ##1 !idle [*6])
    else $error("busy not raised by command");
  a_first_iv: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ15
    (cmd_go && c_op == `SHBA_OP_FIRST && c_alg == SHBA_A256) |=> (v_r[0] == IV[1][0] && hs_r[7] == IV[1][7]))
    else $error("start not from initial hash");
  a_next_keeps: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ16
    (cmd_go && c_op == `SHBA_OP_NEXT) |=> (v_r[0] == $past(hs_r[0]) && $stable(hs_r[3])))
    else $error("continue lost running hash");
  a_narrow_load: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ7
    (cmd_go && c_op != `SHBA_OP_FIN && !c_wide) |=> (w_r[1] == {32'h0, $past(word_r[1])}))
    else $error("narrow block word order wrong");
  a_wide_load: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ5
    (cmd_go && c_op != `SHBA_OP_FIN && c_wide) |=> (w_r[15] == {$past(word_r[30]), $past(word_r[31])}))
    else $error("wide block word order wrong");
  a_pub_160: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ9
    (st_r == SHBA_PUB && alg_r == SHBA_A160) |=> (word_r[4] == $past(hs_r[4][31:0]) && $stable(word_r[5])))
    else $error("160-bit digest placement wrong");
  a_pub_512: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ12
    (st_r == SHBA_PUB && alg_r == SHBA_A512) |=> (word_r[0] == $past(hs_r[0][63:32]) &&
      word_r[15] == $past(hs_r[7][31:0])))
    else $error("512-bit digest placement wrong");
  a_pub_384: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ11
    (st_r == SHBA_PUB && alg_r == SHBA_A384) |=> (word_r[11] == $past(hs_r[5][31:0]) && $stable(word_r[12])))
    else $error("384-bit digest placement wrong");
endmodule // shba_top

// [test/test_shba_top.sv]
// Self-checking bench for the hash block accelerator, driven as a classic Wishbone master.
// Assumes shba_pkg and shba_consts.svh; expected digests are the public test vectors of each algorithm.
`include "shba_consts.svh"
`timescale 1ns/1ps
module test_shba_top;
  import shba_pkg::*;
  logic clk_i; // 40 MHz system clock
  logic rst_i; // Synchronous reset, active high
  shba_wb_req_s wb_r; // Bus request driven by the bench
  shba_wb_rsp_s wb_o; // Bus answer from the design
  int bad_count = 0; // Mismatches seen
  int checks = 0; // Comparisons made
  int cyc_r = 0; // Free-running cycle count for timing and timeout
  int t_ack; // Cycle at which the last access was acknowledged
  logic [31:0] rd; // Data of the last read
  logic [511:0] abc_dig [4]; // Digest of "abc" per algorithm, left justified
  logic [5:0] dig_len [4]; // Digest length in words per algorithm

  shba_top shba_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_r), .wb_o(wb_o));

  // Clock generator, 25 ns period
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Cycle counter; the whole run needs about 1300 cycles, so 20000 means a hang
  always @(posedge clk_i) begin
    cyc_r <= cyc_r + 1;
    if (cyc_r == 20000) begin
      bad_count = bad_count + 1;
      $display("ERROR run length expected below 20000 seen %0d", cyc_r);
      close_out();
    end
  end

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compare one 32-bit value and report a mismatch at once
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic cycle: request held until ack is sampled high, released on that same edge
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_r <= '{1'b1, 1'b1, we, sel, adr, dat};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_o.ack !== 1'b1 && n < 20);
    rd = wb_o.dat;
    t_ack = cyc_r;
    wb_r.cyc <= 1'b0;
    wb_r.stb <= 1'b0;
    if (n >= 20) begin
      cmp("bus acknowledge", 32'h0000_0001, 32'h0000_0000);
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_xfer(1'b1, adr, dat, 4'hf);
  endtask

  task automatic rdw(input logic [7:0] adr);
    wb_xfer(1'b0, adr, 32'h0000_0000, 4'hf);
  endtask

  // Padded one-block "abc"; narrow blocks carry junk above word 15 that must not count
  function automatic logic [31:0] abc_word(input logic wide, input int i);
    if (i == 0) return 32'h6162_6380;
    if (i == (wide ? 31 : 15)) return 32'h0000_0018;
    if (!wide && i >= 16) return 32'h5a5a_0000 | 32'(i);
    return 32'h0000_0000;
  endfunction

  // Issue a command, watch the busy flags and time the operation
  task automatic run_cmd(input logic [1:0] a, input logic [1:0] op, input bit blk, input int lo, input int hi);
    int e;
    int n;
    wr({2'b10, a, op, 2'b00}, 32'h0000_0001);
    e = t_ack;
    if (blk) begin
      for (int b = 0; b < 4; b++) begin
        rdw({2'b10, 2'(b), `SHBA_OP_BUSY, 2'b00});
        cmp("busy flag", {31'h0, 2'(b) == a}, rd);
      end
      // Word and command writes while busy must leave the running hash alone
      wr(8'h50, 32'hdead_beef);
      wr({2'b10, a + 2'd1, `SHBA_OP_FIRST, 2'b00}, 32'h0000_0001);
    end
    n = 0;
    do begin
      rdw({2'b10, a, `SHBA_OP_BUSY, 2'b00});
      n++;
    end while (rd[0] !== 1'b0 && n < 60);
    checks++;
    // Polling resolves time to three cycles, hence the slack on the upper bound
    if (t_ack - 1 - e < lo || t_ack - 1 - e > hi + 3 || n >= 60) begin
      bad_count++;
      $display("ERROR operation cycles expected %0d to %0d seen %0d", lo, hi, t_ack - 1 - e);
    end
  endtask

  // Read back the digest words of one algorithm
  task automatic chk_digest(input logic [1:0] a, input logic [511:0] d);
    for (int k = 0; k < 16; k++) begin
      if (k < dig_len[a]) begin
        rdw(8'(4 * k));
        cmp("digest word", d[511 - 32 * k -: 32], rd);
      end
    end
  endtask

  // Main sequence
  initial begin
    logic [7:0] c;
    abc_dig[0] = {160'ha999_3e36_4706_816a_ba3e_2571_7850_c26c_9cd0_d89d, 352'h0};
    abc_dig[1] = {256'hba78_16bf_8f01_cfea_4141_40de_5dae_2223_b003_61a3_9617_7a9c_b410_ff61_f200_15ad, 256'h0};
    abc_dig[2] = {192'hcb00_753f_45a3_5e8b_b5a0_3d69_9ac6_5007_272c_32ab_0ede_d163,
                  192'h1a8b_605a_43ff_5bed_8086_072b_a1e7_cc23_58ba_eca1_34c8_25a7, 128'h0};
    abc_dig[3] = {256'hddaf_35a1_9361_7aba_cc41_7349_ae20_4131_12e6_fa4e_89a9_7ea2_0a9e_eee6_4b55_d39a,
                  256'h2192_992a_274f_c1a8_36ba_3c23_a3fe_ebbd_454d_4423_643c_e80e_2a9a_c94f_a54c_a49f};
    dig_len[0] = `SHBA_DIG_160;
    dig_len[1] = `SHBA_DIG_256;
    dig_len[2] = `SHBA_DIG_384;
    dig_len[3] = `SHBA_DIG_512;
    wb_r = '0;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;

    // Idle state, write-only and unmapped places, refused command writes
    rdw(8'h00);
    cmp("word 0 after reset", 32'h0000_0000, rd);
    for (int b = 0; b < 4; b++) begin
      rdw({2'b10, 2'(b), `SHBA_OP_BUSY, 2'b00});
      cmp("busy flag after reset", 32'h0000_0000, rd);
    end
    rdw(8'h80);
    cmp("command place read", 32'h0000_0000, rd);
    wr(8'hc0, 32'hffff_ffff);
    rdw(8'hc0);
    cmp("unmapped place read", 32'h0000_0000, rd);
    wr(8'h80, 32'h0000_0002);
    wb_xfer(1'b1, 8'h90, 32'h0000_0001, 4'he);
    rdw(8'h8c);
    cmp("busy after zero command", 32'h0000_0000, rd);
    rdw(8'h9c);
    cmp("busy after masked command", 32'h0000_0000, rd);
    $display("test reset and access done");

    // Two-block narrow message: first block, then continue, then finalize
    for (int i = 0; i < 16; i++) begin
      c = 8'h61 + 8'(i);
      wr(8'(4 * i), (i < 14) ? {c, c + 8'h1, c + 8'h2, c + 8'h3} : ((i == 14) ? 32'h8000_0000 : 32'h0000_0000));
    end
    run_cmd(2'd1, `SHBA_OP_FIRST, 1'b1, 60, 100);
    for (int i = 0; i < 16; i++) begin
      wr(8'(4 * i), (i == 15) ? 32'h0000_01c0 : 32'h0000_0000);
    end
    run_cmd(2'd1, `SHBA_OP_NEXT, 1'b1, 60, 100);
    run_cmd(2'd1, `SHBA_OP_FIN, 1'b0, 8, 20);
    chk_digest(2'd1, {256'h248d_6a61_d206_38b8_e5c0_2693_0c3e_6039_a33c_e459_64ff_2167_f6ec_edd4_19db_06c1,
                      256'h0});
    $display("test two-block hash done");

    // One block per algorithm, each a fresh start after the previous state
    for (int a = 0; a < 4; a++) begin
      for (int i = 0; i < 32; i++) begin
        wr(8'(4 * i), abc_word(a[1], i));
      end
      run_cmd(2'(a), `SHBA_OP_FIRST, 1'b1, 60, 100);
      run_cmd(2'(a), `SHBA_OP_FIN, 1'b0, 8, 20);
      chk_digest(2'(a), abc_dig[a]);
      rdw(8'h50);
      cmp("word 20 after busy write", abc_word(a[1], 20), rd);
      rdw(8'h7c);
      cmp("word 31 above digest", abc_word(a[1], 31), rd);
      $display("test one-block hash of algorithm %0d done", a);
    end
    close_out();
  end
endmodule // test_shba_top
